// ===== rtl/efp_fifo_pair.sv
`timescale 1ns/1ps
`include "efp_defines.svh"
module efp_fifo_pair (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [12:0] tx_threshold,
  input wire logic runt_discard_en,
  input wire logic bad_frame_auto,
  input wire logic tx_wr_valid,
  input wire logic [7:0] tx_wr_data,
  input wire logic tx_wr_last,
  output logic tx_wr_ready,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output logic tx_out_last,
  input wire logic tx_out_ready,
  input wire logic tx_retry,
  input wire logic rx_in_valid,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_last,
  input wire logic rx_in_bad,
  output logic rx_in_ready,
  output logic rx_rd_valid,
  output logic [7:0] rx_rd_data,
  output logic rx_rd_last,
  output logic rx_rd_bad,
  input wire logic rx_rd_ready
);
  // ****************************************
  // transmit buffer
  // ****************************************
  logic [8:0] tx_mem [0:`EFP_DEPTH-1];
  logic [11:0] tx_wp_q, tx_rp_q, tx_fs_q;
  logic [12:0] tx_cnt_q, tx_sent_q, tx_thr_q;
  // frame count holds up to 255 queued frames; legal frames of 64 bytes or more never reach it
  logic [7:0] tx_frames_q;
  efp_pkg::efp_tx_state_e tx_st_q;
  logic tx_out_valid_q, tx_out_last_q;
  logic [7:0] tx_out_data_q;

  wire tx_push = tx_wr_valid && tx_wr_ready;
  wire tx_can_take = tx_out_ready || !tx_out_valid_q;
  wire tx_has = tx_cnt_q != tx_sent_q;
  // read offset from frame start is tx_sent_q
  wire [11:0] tx_rd_addr = tx_rp_q;
  wire tx_pop = (tx_st_q == efp_pkg::EFP_TX_SEND) && tx_can_take && tx_has && !tx_retry;
  wire [8:0] tx_word = tx_mem[tx_rd_addr];
  wire tx_pop_last = tx_pop && tx_word[8];
  // a committed frame always starts, whatever the threshold says
  wire tx_go = (tx_frames_q != 8'h00) || (tx_cnt_q >= tx_thr_q);
  wire [11:0] tx_wp_inc = (tx_wp_q == 12'(`EFP_DEPTH - 1)) ? 12'h000 : tx_wp_q + 12'h001;
  wire [11:0] tx_rp_inc = (tx_rp_q == 12'(`EFP_DEPTH - 1)) ? 12'h000 : tx_rp_q + 12'h001;
  wire tx_wlast = tx_push && tx_wr_last;
  // only committed frames count toward the whole-frame start, partial one counts bytes
  wire [12:0] tx_cnt_d = tx_cnt_q + (tx_push ? 13'h0001 : 13'h0000)
    - (tx_pop_last ? tx_sent_q + 13'h0001 : 13'h0000);

  // storage has no reset; pointers, counts, state, ready and output registers do
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp_q] <= {tx_wr_last, tx_wr_data};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wp_q <= 12'h000;
      tx_wr_ready <= 1'b1;
      tx_frames_q <= 8'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_inc;
      // space counts bytes of the frame being sent, which stay for a retry
      tx_wr_ready <= (tx_cnt_d < 13'(`EFP_DEPTH));
      tx_frames_q <= tx_frames_q + (tx_wlast ? 8'h01 : 8'h00) - (tx_pop_last ? 8'h01 : 8'h00);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_q <= 13'h0000;
      tx_thr_q <= `EFP_THR_RESET;
      tx_st_q <= efp_pkg::EFP_TX_IDLE;
      tx_rp_q <= 12'h000;
      tx_fs_q <= 12'h000;
      tx_sent_q <= 13'h0000;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      case (tx_st_q)
        efp_pkg::EFP_TX_IDLE: begin
          tx_thr_q <= tx_threshold;
          // wait until the held last byte leaves, so frames stay one idle cycle apart
          if (tx_go && tx_can_take) tx_st_q <= efp_pkg::EFP_TX_SEND;
        end
        efp_pkg::EFP_TX_SEND: begin
          if (tx_retry) begin
            tx_rp_q <= tx_fs_q;
            tx_sent_q <= 13'h0000;
            tx_st_q <= efp_pkg::EFP_TX_GAP;
          end else if (tx_pop_last) begin
            tx_rp_q <= tx_rp_inc;
            tx_fs_q <= tx_rp_inc;
            tx_sent_q <= 13'h0000;
            tx_st_q <= efp_pkg::EFP_TX_IDLE;
          end else if (tx_pop) begin
            tx_rp_q <= tx_rp_inc;
            tx_sent_q <= tx_sent_q + 13'h0001;
          end
        end
        efp_pkg::EFP_TX_GAP: begin
          if (!tx_out_valid_q) tx_st_q <= efp_pkg::EFP_TX_SEND;
        end
        default: tx_st_q <= efp_pkg::EFP_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out_valid_q <= 1'b0;
      tx_out_data_q <= 8'h00;
      tx_out_last_q <= 1'b0;
    end else if (tx_retry) begin
      tx_out_valid_q <= 1'b0;
    end else if (tx_can_take) begin
      tx_out_valid_q <= tx_pop;
      tx_out_data_q <= tx_word[7:0];
      tx_out_last_q <= tx_word[8];
    end
  end

  assign tx_out_valid = tx_out_valid_q;
  assign tx_out_data = tx_out_data_q;
  assign tx_out_last = tx_out_last_q;

  // ****************************************
  // receive buffer
  // ****************************************
  logic [9:0] rx_mem [0:`EFP_DEPTH-1];
  logic [11:0] rx_wp_q, rx_fs_q, rx_rp_q;
  logic [12:0] rx_used_q, rx_flen_q, rx_commit_q;
  logic rx_rd_valid_q, rx_rd_last_q, rx_rd_bad_q;
  logic [7:0] rx_rd_data_q;

  wire rx_push = rx_in_valid && rx_in_ready;
  wire rx_end = rx_push && rx_in_last;
  wire [12:0] rx_len = rx_flen_q + 13'h0001;
  wire rx_runt = rx_len < `EFP_RUNT_BYTES;
  wire rx_drop = rx_end && ((runt_discard_en && rx_runt) || (bad_frame_auto && rx_in_bad));
  wire rx_keep = rx_end && !rx_drop;
  wire [11:0] rx_wp_inc = (rx_wp_q == 12'(`EFP_DEPTH - 1)) ? 12'h000 : rx_wp_q + 12'h001;
  wire [11:0] rx_rp_inc = (rx_rp_q == 12'(`EFP_DEPTH - 1)) ? 12'h000 : rx_rp_q + 12'h001;
  // output register refills in the cycle its byte is taken
  wire rx_can_take = rx_rd_ready || !rx_rd_valid_q;
  wire rx_pop = rx_can_take && (rx_commit_q != 13'h0000);
  wire [9:0] rx_word = rx_mem[rx_rp_q];
  wire [12:0] rx_used_d = rx_used_q + (rx_push ? 13'h0001 : 13'h0000)
    - (rx_drop ? rx_len : 13'h0000) - (rx_pop ? 13'h0001 : 13'h0000);

  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp_q] <= {rx_in_bad, rx_in_last, rx_in_data};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= 12'h000;
      rx_fs_q <= 12'h000;
      rx_flen_q <= 13'h0000;
      rx_used_q <= 13'h0000;
      rx_in_ready <= 1'b1;
    end else begin
      rx_used_q <= rx_used_d;
      rx_in_ready <= (rx_used_d < 13'(`EFP_DEPTH));
      // a dropped frame rewinds the write pointer to its own first byte
      if (rx_drop) begin
        rx_wp_q <= rx_fs_q;
        rx_flen_q <= 13'h0000;
      end else if (rx_keep) begin
        rx_wp_q <= rx_wp_inc;
        rx_fs_q <= rx_wp_inc;
        rx_flen_q <= 13'h0000;
      end else if (rx_push) begin
        rx_wp_q <= rx_wp_inc;
        rx_flen_q <= rx_len;
      end
    end
  end

  // host sees only whole accepted frames, so a later drop never rewinds read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_commit_q <= 13'h0000;
      rx_rp_q <= 12'h000;
      rx_rd_valid_q <= 1'b0;
      rx_rd_data_q <= 8'h00;
      rx_rd_last_q <= 1'b0;
      rx_rd_bad_q <= 1'b0;
    end else begin
      rx_commit_q <= rx_commit_q + (rx_keep ? rx_len : 13'h0000) - (rx_pop ? 13'h0001 : 13'h0000);
      if (rx_pop) rx_rp_q <= rx_rp_inc;
      if (rx_can_take) begin
        rx_rd_valid_q <= rx_pop;
        rx_rd_data_q <= rx_word[7:0];
        rx_rd_last_q <= rx_word[8];
        rx_rd_bad_q <= rx_word[9] && rx_word[8];
      end
    end
  end

  assign rx_rd_valid = rx_rd_valid_q;
  assign rx_rd_data = rx_rd_data_q;
  assign rx_rd_last = rx_rd_last_q;
  assign rx_rd_bad = rx_rd_bad_q;
endmodule : efp_fifo_pair

// ===== rtl/efp_defines.svh
`ifndef EFP_DEFINES_SVH
`define EFP_DEFINES_SVH
// 3 Kbyte per buffer, one byte per entry
`define EFP_DEPTH 3072
`define EFP_AW 12
`define EFP_CW 13
`define EFP_RUNT_BYTES 13'h0040
`define EFP_THR_RESET 13'h0200
`endif

// ===== rtl/efp_pkg.sv
package efp_pkg;
  typedef enum logic [1:0] {
    EFP_TX_IDLE = 2'b00,
    EFP_TX_SEND = 2'b01,
    EFP_TX_GAP = 2'b10
  } efp_tx_state_e;
endpackage : efp_pkg

// ===== bench/efp_properties.sv
`timescale 1ns/1ps
// ****
// fifo pair checks
// ****
module efp_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic runt_discard_en,
  input wire logic tx_wr_valid,
  input wire logic tx_wr_ready,
  input wire logic tx_wr_last,
  input wire logic tx_out_valid,
  input wire logic tx_out_last,
  input wire logic tx_out_ready,
  input wire logic tx_retry,
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic rx_in_last,
  input wire logic rx_in_bad,
  input wire logic rx_rd_valid,
  input wire logic rx_rd_last,
  input wire logic rx_rd_bad,
  input wire logic rx_rd_ready,
  input wire logic [7:0] tx_out_data,
  input wire logic [7:0] rx_rd_data
);
  logic [12:0] n_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) n_q <= 13'h0000;
    else if (rx_in_valid && rx_in_ready) n_q <= rx_in_last ? 13'h0000 : n_q + 13'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_tx_end; tx_wr_valid && tx_wr_ready && tx_wr_last && !tx_out_valid; endsequence
  sequence s_rx_end; rx_in_valid && rx_in_ready && rx_in_last && !rx_in_bad && !rx_rd_valid;
  endsequence
  property p_tx_hold; tx_out_valid && !tx_out_ready && !tx_retry |=>
    tx_out_valid && $stable({tx_out_data, tx_out_last}); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx out moved");
  property p_rx_hold; rx_rd_valid && !rx_rd_ready |=>
    rx_rd_valid && $stable({rx_rd_data, rx_rd_last, rx_rd_bad}); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx out moved");
  property p_bad_last; rx_rd_valid && rx_rd_bad |-> rx_rd_last; endproperty
  a_bad_last: assert property (p_bad_last) else $error("bad flag early");
  property p_tx_start; s_tx_end |-> ##[1:6] tx_out_valid; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx did not start");
  property p_rx_keep; s_rx_end ##0 !runt_discard_en |-> ##[1:4] rx_rd_valid; endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx frame lost");
  property p_rx_full; s_rx_end ##0 (n_q > 13'h003E) |-> ##[1:4] rx_rd_valid; endproperty
  a_rx_full: assert property (p_rx_full) else $error("full rx frame lost");
  property p_rst_rdy; $rose(rst_n) |-> tx_wr_ready && rx_in_ready; endproperty
  a_rst_rdy: assert property (p_rst_rdy) else $error("not ready after reset");
  property p_tx_last; tx_out_valid && tx_out_ready && tx_out_last |=> !tx_out_valid; endproperty
  a_tx_last: assert property (p_tx_last) else $error("no gap after frame");
endmodule : efp_properties
bind efp_fifo_pair efp_properties u_props (.*);

// ===== bench/efp_mac_model.sv
`timescale 1ns/1ps
// ****
// mac side model
// ****
module efp_mac_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_out_valid,
  input wire logic tx_out_last,
  input wire logic stall,
  input wire logic [12:0] retry_at,
  output logic tx_out_ready,
  output logic tx_retry
);
  logic [12:0] n_q;
  logic fired_q;
  wire take = tx_out_valid && tx_out_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_q <= 13'h0000;
      fired_q <= 1'b0;
      tx_retry <= 1'b0;
      tx_out_ready <= 1'b0;
    end else begin
      tx_retry <= 1'b0;
      tx_out_ready <= !stall || 1'($urandom_range(0, 1));
      if (take) n_q <= tx_out_last ? 13'h0000 : n_q + 13'h0001;
      // ready drops in the retry cycle so no byte is taken twice
      if (take && !tx_out_last && !fired_q && n_q + 13'h0001 == retry_at) begin
        tx_retry <= 1'b1;
        tx_out_ready <= 1'b0;
        fired_q <= 1'b1;
        n_q <= 13'h0000;
      end
    end
  end
endmodule : efp_mac_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
// ****
// fifo pair bench
// ****
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, runt_discard_en = 1'b0, bad_frame_auto = 1'b0, stall = 1'b0;
  logic tx_wr_valid = 1'b0, tx_wr_last = 1'b0, rx_in_valid = 1'b0, rx_in_last = 1'b0;
  logic rx_in_bad = 1'b0, rx_rd_ready = 1'b0;
  logic [7:0] tx_wr_data = 8'h00, rx_in_data = 8'h00;
  logic [12:0] tx_threshold = 13'h0200, retry_at = 13'h0000;
  wire tx_wr_ready, tx_out_valid, tx_out_last, tx_out_ready, tx_retry, rx_in_ready;
  wire rx_rd_valid, rx_rd_last, rx_rd_bad;
  wire [7:0] tx_out_data, rx_rd_data;
  logic [9:0] txq[$], rxq[$];
  int errors = 0, checks_done = 0;
  efp_fifo_pair dut (.*);
  efp_mac_model mac (.*);
  always #5 clk = ~clk;
  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  always @(posedge clk) begin
    if (rst_n && tx_out_valid && tx_out_ready) chk("tx", txq.size() ? txq.pop_front() : 'x,
      {1'b0, tx_out_last, tx_out_data});
    if (rst_n && rx_rd_valid && rx_rd_ready) chk("rx", rxq.size() ? rxq.pop_front() : 'x,
      {rx_rd_bad, rx_rd_last, rx_rd_data});
    rx_rd_ready <= 1'($urandom_range(0, 1));
  end
  task automatic tx_frame(int len, int k);
    logic [7:0] f[$];
    for (int i = 0; i < len; i++) f.push_back(8'($urandom));
    for (int i = 0; i < k; i++) txq.push_back({2'b00, f[i]});
    for (int i = 0; i < len; i++) txq.push_back({1'b0, i == len - 1, f[i]});
    for (int i = 0; i < len; i++) begin
      tx_wr_valid <= 1'b1;
      tx_wr_data <= f[i];
      tx_wr_last <= i == len - 1;
      do @(posedge clk); while (!tx_wr_ready);
    end
    tx_wr_valid <= 1'b0;
    @(posedge clk);
  endtask : tx_frame
  task automatic rx_frame(int len, logic bad);
    logic [7:0] b;
    logic keep;
    keep = !(runt_discard_en && len < 64) && !(bad && bad_frame_auto);
    for (int i = 0; i < len; i++) begin
      b = 8'($urandom);
      if (keep) rxq.push_back({bad && i == len - 1, i == len - 1, b});
      rx_in_valid <= 1'b1;
      rx_in_data <= b;
      rx_in_last <= i == len - 1;
      rx_in_bad <= bad;
      do @(posedge clk); while (!rx_in_ready);
    end
    rx_in_valid <= 1'b0;
    @(posedge clk);
  endtask : rx_frame
  task automatic drain(string name);
    for (int i = 0; i < 3000 && (txq.size() || rxq.size()); i++) @(posedge clk);
    // a tail lets a frame that should have been dropped show up against an empty queue
    repeat (20) @(posedge clk);
    chk("left", 10'h000, 10'(txq.size() + rxq.size()));
    $display("test %s done", name);
  endtask : drain
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(61333));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    tx_frame(20, 0);
    tx_frame(70, 0);
    drain("back to back");
    tx_threshold <= 13'h0010;
    stall <= 1'b1;
    tx_frame(100, 0);
    chk("early start", 10'h001, 10'(txq.size() < 100));
    drain("threshold");
    stall <= 1'b0;
    retry_at <= 13'h000A;
    tx_frame(40, 10);
    drain("retry");
    for (int m = 0; m < 4; m++) begin
      runt_discard_en <= m[0];
      bad_frame_auto <= m[1];
      @(posedge clk);
      rx_frame(63, 1'b0);
      rx_frame(64, 1'b0);
      rx_frame(80, 1'b1);
      drain("rx mode");
    end
    complete_run;
  end
endmodule : tb_top
